// ### hw/sfrcs_consts.vh
// Purpose: shared constants of the serial flash read capture and status block
// Assumes: 32-bit register bus, byte addresses
// Notes: offsets are byte addresses on the register port
`ifndef SFRCS_CONSTS_VH
`define SFRCS_CONSTS_VH

`define SFRCS_ADDR_W 8
`define SFRCS_OFS_CTRL 8'h04
`define SFRCS_OFS_DATA 8'h08
`define SFRCS_OFS_RD_COUNT 8'h20
`define SFRCS_OFS_TIMING 8'h24
`define SFRCS_OFS_SECONDARY_CONFIG 8'h28
`define SFRCS_OFS_STATUS 8'h2C
`define SFRCS_OFS_MASK 8'h30
`define SFRCS_OFS_RAW 8'h34
`define SFRCS_OFS_CLEAR 8'h38

`define SFRCS_CTRL_START 15
`define SFRCS_CTRL_STOP 14
`define SFRCS_CTRL_POL 8
`define SFRCS_CTRL_PHA 7
`define SFRCS_TIMING_CAPT 6
`define SFRCS_COUNT_W 20
`define SFRCS_SECONDARY_CONFIG_WR_LO 12
`define SFRCS_SECONDARY_CONFIG_RD_LO 8

`define SFRCS_ST_WQ_OVF 11
`define SFRCS_ST_WQ_UNF 10
`define SFRCS_ST_RQ_OVF 9
`define SFRCS_ST_RQ_UNF 8
`define SFRCS_ST_WQ_FULL 7
`define SFRCS_ST_WQ_EMPTY 6
`define SFRCS_ST_RQ_FULL 5
`define SFRCS_ST_RQ_EMPTY 4
`define SFRCS_ST_WQ_BURST 3
`define SFRCS_ST_RQ_BURST 2
`define SFRCS_ST_READY 1
`define SFRCS_ST_DONE 0
`define SFRCS_ST_W 12

`define SFRCS_MASK_RESET 12'hFFF
`define SFRCS_DONE_RESET 1'b1

`define SFRCS_CLK_NS 5
`define SFRCS_SCLK_HALF_NS 20
`define SFRCS_SCLK_HALF_CYC ((`SFRCS_SCLK_HALF_NS + `SFRCS_CLK_NS - 1) / `SFRCS_CLK_NS)

`endif

// ### hw/sfrcs_rd_queue.v
// Purpose: read queue holding captured words until software pops them
// Assumes: single clock, show-ahead head word
// Notes: push while full and pop while empty are dropped; caller flags them
`default_nettype none

module sfrcs_rd_queue #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock,
	input wire rstn,
	input wire push,
	input wire [WIDTH-1:0] push_data,
	input wire pop,
	output wire [WIDTH-1:0] head_data,
	output wire full,
	output wire empty,
	output wire [AW:0] level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] level_reg;
	wire do_push;
	wire do_pop;

	assign full = (level_reg == DEPTH[AW:0]);
	assign empty = (level_reg == {(AW+1){1'b0}});
	assign level = level_reg;
	assign head_data = mem[rd_ptr_reg];
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;

	always @(posedge clock) begin
		if (do_push) begin
			mem[wr_ptr_reg] <= push_data;
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			level_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (do_push && !do_pop) begin
				level_reg <= level_reg + 1'b1;
			end else if (do_pop && !do_push) begin
				level_reg <= level_reg - 1'b1;
			end
		end
	end
endmodule // sfrcs_rd_queue

`default_nettype wire

// ### hw/sfrcs_top.v
// Purpose: serial flash read engine with capture edge select and masked status
// Assumes: this block drives the serial clock and chip select; data pin is asynchronous
// Notes: the write path lives elsewhere, so its queue reads as permanently empty
//
// Local design decision: strobed register access.
`include "sfrcs_consts.vh"
`default_nettype none

module sfrcs_top #(
	parameter SCLK_HALF_CYC = `SFRCS_SCLK_HALF_CYC,
	parameter RQ_DEPTH = 8,
	parameter RQ_AW = 3,
	parameter WQ_DEPTH = 8
) (
	input wire clock,
	input wire rstn,
	input wire [`SFRCS_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [31:0] reg_rdata,
	output reg sclk,
	output reg flash_cs_n,
	input wire flash_din
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN = 3'b010;
	localparam [2:0] ST_END = 3'b100;
	localparam [31:0] HALF_LAST_W = SCLK_HALF_CYC - 1;
	localparam [7:0] HALF_LAST = HALF_LAST_W[7:0];
	// the write queue lives elsewhere, so all of its entries count as free
	localparam [31:0] WQ_FREE_W = WQ_DEPTH;
	localparam [RQ_AW:0] WQ_FREE = WQ_FREE_W[RQ_AW:0];

	// software-visible configuration
	reg sclk_idle_polarity_reg;
	reg sclk_phase_select_reg;
	reg capt_edge_reg;
	reg [`SFRCS_COUNT_W-1:0] rd_count_reg;
	reg [1:0] wr_burst_reg;
	reg [1:0] rd_burst_reg;
	reg [`SFRCS_ST_W-1:0] mask_reg;

	// event state
	reg rq_ovf_reg;
	reg rq_unf_reg;
	reg done_reg;
	reg stop_req_reg;

	// serial engine
	reg [2:0] state_reg;
	reg [7:0] div_cnt_reg;
	reg [2:0] bit_cnt_reg;
	reg [1:0] lane_reg;
	reg [7:0] byte_sh_reg;
	reg [31:0] word_reg;
	reg [`SFRCS_COUNT_W-1:0] bytes_left_reg;
	reg continuous_reg;
	reg [1:0] cap_pipe_reg;
	reg din_meta_reg;
	reg din_sync_reg;

	wire wr_ctrl;
	wire start_req;
	wire stop_hit;
	wire pop_req;
	wire q_full;
	wire q_empty;
	wire [RQ_AW:0] q_level;
	wire [31:0] q_head;
	wire capture_rising;
	wire div_end;
	wire new_sclk;
	wire toggle_ok;
	wire sclk_at_idle;
	wire sample_now;
	wire [7:0] byte_done;
	wire byte_end;
	wire last_byte;
	wire [31:0] word_next;
	wire q_push;
	wire clr_write;
	wire [`SFRCS_ST_W-1:0] raw_status;
	wire [`SFRCS_ST_W-1:0] masked_status;
	reg [31:0] rdata_next;

	assign wr_ctrl = reg_write && (reg_addr == `SFRCS_OFS_CTRL);
	assign start_req = wr_ctrl && reg_wdata[`SFRCS_CTRL_START] && state_reg[0];
	assign stop_hit = wr_ctrl && reg_wdata[`SFRCS_CTRL_STOP];
	assign pop_req = reg_read && (reg_addr == `SFRCS_OFS_DATA);
	assign clr_write = reg_write && (reg_addr == `SFRCS_OFS_CLEAR);

	// capture edge: the select bit flips whichever edge the polarity/phase pair picks
	assign capture_rising = (sclk_idle_polarity_reg == sclk_phase_select_reg) ^ capt_edge_reg;

	assign div_end = (div_cnt_reg == HALF_LAST);
	assign new_sclk = ~sclk;
	assign sclk_at_idle = (sclk == sclk_idle_polarity_reg);
	// only park at the idle level so a full queue never leaves half a clock pulse
	assign toggle_ok = !(q_full && sclk_at_idle);

	// the data pin is two flops late, so sampling waits for the same two cycles
	assign sample_now = cap_pipe_reg[1] && state_reg[1];
	assign byte_done = {byte_sh_reg[6:0], din_sync_reg};
	assign byte_end = sample_now && (bit_cnt_reg == 3'h7);
	assign last_byte = (!continuous_reg && (bytes_left_reg == 20'h00001)) || stop_req_reg;
	assign word_next = (lane_reg == 2'h0) ? {24'h000000, byte_done} :
		(lane_reg == 2'h1) ? {word_reg[31:16], byte_done, word_reg[7:0]} :
		(lane_reg == 2'h2) ? {word_reg[31:24], byte_done, word_reg[15:0]} :
		{byte_done, word_reg[23:0]};
	assign q_push = byte_end && ((lane_reg == 2'h3) || last_byte);

	// the engine parks before a push can meet a full queue; overflow stays a guard
	sfrcs_rd_queue #(
		.WIDTH(32),
		.DEPTH(RQ_DEPTH),
		.AW(RQ_AW)
	) u_rd_queue (
		.clock(clock),
		.rstn(rstn),
		.push(q_push),
		.push_data(word_next),
		.pop(pop_req),
		.head_data(q_head),
		.full(q_full),
		.empty(q_empty),
		.level(q_level)
	);

	// the write queue is outside this block and always reads as empty
	assign raw_status[`SFRCS_ST_WQ_OVF] = 1'b0;
	assign raw_status[`SFRCS_ST_WQ_UNF] = 1'b0;
	assign raw_status[`SFRCS_ST_RQ_OVF] = rq_ovf_reg;
	assign raw_status[`SFRCS_ST_RQ_UNF] = rq_unf_reg;
	assign raw_status[`SFRCS_ST_WQ_FULL] = 1'b0;
	assign raw_status[`SFRCS_ST_WQ_EMPTY] = 1'b1;
	assign raw_status[`SFRCS_ST_RQ_FULL] = q_full;
	assign raw_status[`SFRCS_ST_RQ_EMPTY] = q_empty;
	assign raw_status[`SFRCS_ST_WQ_BURST] = (WQ_FREE >= {{(RQ_AW-1){1'b0}}, wr_burst_reg});
	assign raw_status[`SFRCS_ST_RQ_BURST] = (q_level >= {{(RQ_AW-1){1'b0}}, rd_burst_reg});
	assign raw_status[`SFRCS_ST_READY] = state_reg[0];
	assign raw_status[`SFRCS_ST_DONE] = done_reg;
	assign masked_status = raw_status & ~mask_reg;

	// reading the data window pops the head, so an empty read flags underflow
	always @* begin
		rdata_next = 32'h00000000;
		case (reg_addr)
			`SFRCS_OFS_CTRL: begin
				rdata_next[`SFRCS_CTRL_POL] = sclk_idle_polarity_reg;
				rdata_next[`SFRCS_CTRL_PHA] = sclk_phase_select_reg;
			end
			`SFRCS_OFS_DATA: rdata_next = q_empty ? 32'h00000000 : q_head;
			`SFRCS_OFS_RD_COUNT: rdata_next[`SFRCS_COUNT_W-1:0] = rd_count_reg;
			`SFRCS_OFS_TIMING: rdata_next[`SFRCS_TIMING_CAPT] = capt_edge_reg;
			`SFRCS_OFS_SECONDARY_CONFIG: begin
				rdata_next[`SFRCS_SECONDARY_CONFIG_WR_LO+1:`SFRCS_SECONDARY_CONFIG_WR_LO] = wr_burst_reg;
				rdata_next[`SFRCS_SECONDARY_CONFIG_RD_LO+1:`SFRCS_SECONDARY_CONFIG_RD_LO] = rd_burst_reg;
			end
			`SFRCS_OFS_STATUS: rdata_next[`SFRCS_ST_W-1:0] = masked_status;
			`SFRCS_OFS_MASK: rdata_next[`SFRCS_ST_W-1:0] = mask_reg;
			`SFRCS_OFS_RAW: rdata_next[`SFRCS_ST_W-1:0] = raw_status;
			default: rdata_next = 32'h00000000;
		endcase
	end

	// register port: read data stands only in the cycle after the strobe
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// configuration writes; reserved bits are dropped so their write value is moot
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sclk_idle_polarity_reg <= 1'b0;
			sclk_phase_select_reg <= 1'b0;
			capt_edge_reg <= 1'b0;
			rd_count_reg <= 20'h00000;
			wr_burst_reg <= 2'h0;
			rd_burst_reg <= 2'h0;
			mask_reg <= `SFRCS_MASK_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				`SFRCS_OFS_CTRL: begin
					// changing the clock shape mid-transfer would tear the frame
					if (state_reg[0]) begin
						sclk_idle_polarity_reg <= reg_wdata[`SFRCS_CTRL_POL];
						sclk_phase_select_reg <= reg_wdata[`SFRCS_CTRL_PHA];
					end
				end
				`SFRCS_OFS_RD_COUNT: rd_count_reg <= reg_wdata[`SFRCS_COUNT_W-1:0];
				`SFRCS_OFS_TIMING: capt_edge_reg <= reg_wdata[`SFRCS_TIMING_CAPT];
				`SFRCS_OFS_SECONDARY_CONFIG: begin
					wr_burst_reg <= reg_wdata[`SFRCS_SECONDARY_CONFIG_WR_LO+1:`SFRCS_SECONDARY_CONFIG_WR_LO];
					rd_burst_reg <= reg_wdata[`SFRCS_SECONDARY_CONFIG_RD_LO+1:`SFRCS_SECONDARY_CONFIG_RD_LO];
				end
				`SFRCS_OFS_MASK: mask_reg <= reg_wdata[`SFRCS_ST_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// sticky queue errors: a new event in the clearing cycle survives the clear
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rq_ovf_reg <= 1'b0;
			rq_unf_reg <= 1'b0;
		end else begin
			if (q_push && q_full) begin
				rq_ovf_reg <= 1'b1;
			end else if (clr_write && reg_wdata[`SFRCS_ST_RQ_OVF]) begin
				rq_ovf_reg <= 1'b0;
			end
			if (pop_req && q_empty) begin
				rq_unf_reg <= 1'b1;
			end else if (clr_write && reg_wdata[`SFRCS_ST_RQ_UNF]) begin
				rq_unf_reg <= 1'b0;
			end
		end
	end

	// data pin synchroniser
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= flash_din;
			din_sync_reg <= din_meta_reg;
		end
	end

	// serial engine; half period must exceed the two-cycle sample delay
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			sclk <= 1'b0;
			flash_cs_n <= 1'b1;
			div_cnt_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			lane_reg <= 2'h0;
			byte_sh_reg <= 8'h00;
			word_reg <= 32'h00000000;
			bytes_left_reg <= 20'h00000;
			continuous_reg <= 1'b0;
			cap_pipe_reg <= 2'h0;
			stop_req_reg <= 1'b0;
			done_reg <= `SFRCS_DONE_RESET;
		end else begin
			cap_pipe_reg <= {cap_pipe_reg[0], 1'b0};
			case (state_reg)
				ST_IDLE: begin
					sclk <= sclk_idle_polarity_reg;
					if (start_req) begin
						state_reg <= ST_RUN;
						flash_cs_n <= 1'b0;
						div_cnt_reg <= 8'h00;
						bit_cnt_reg <= 3'h0;
						lane_reg <= 2'h0;
						word_reg <= 32'h00000000;
						bytes_left_reg <= rd_count_reg;
						continuous_reg <= (rd_count_reg == 20'h00000);
						stop_req_reg <= 1'b0;
						done_reg <= 1'b0;
					end
				end
				ST_RUN: begin
					if (stop_hit) begin
						stop_req_reg <= 1'b1;
					end
					if (div_end) begin
						if (toggle_ok) begin
							div_cnt_reg <= 8'h00;
							sclk <= new_sclk;
							// only capture edges enter the pipe; shift edges leave the sampler alone
							cap_pipe_reg <= {cap_pipe_reg[0], (new_sclk == capture_rising)};
						end
					end else begin
						div_cnt_reg <= div_cnt_reg + 8'h01;
					end
					if (sample_now) begin
						byte_sh_reg <= byte_done;
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
					if (byte_end) begin
						word_reg <= word_next;
						lane_reg <= lane_reg + 2'h1;
						bytes_left_reg <= bytes_left_reg - 20'h00001;
						if (last_byte) begin
							state_reg <= ST_END;
						end
					end
				end
				ST_END: begin
					// bring the clock back to its idle level before releasing select
					if (!sclk_at_idle) begin
						if (div_end) begin
							div_cnt_reg <= 8'h00;
							sclk <= new_sclk;
						end else begin
							div_cnt_reg <= div_cnt_reg + 8'h01;
						end
					end else begin
						// ready and done rise in the same cycle as select is released
						flash_cs_n <= 1'b1;
						done_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					flash_cs_n <= 1'b1;
					sclk <= sclk_idle_polarity_reg;
					div_cnt_reg <= 8'h00;
					stop_req_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			endcase
		end
	end
endmodule // sfrcs_top

`default_nettype wire

// ### tb/sfrcs_props.sv
// Purpose: checker for read-back, masked status and serial clock framing
// Assumes: status and mask reads answer in the following cycle
// Notes: the write queue is absent, so its flags are constants
`include "sfrcs_consts.vh"
`default_nettype none
module sfrcs_props #(
	parameter int SCLK_HALF_CYC = 4
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic sclk,
	input wire logic flash_cs_n,
	input wire logic flash_din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] mask_reg;
	logic pol_reg;
	int unsigned hold_cnt;
	logic sclk_q;
	// polarity writes during a frame are ignored by the block
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mask_reg <= `SFRCS_MASK_RESET;
			pol_reg <= 1'b0;
		end else begin
			if (reg_write && reg_addr == `SFRCS_OFS_MASK)
				mask_reg <= reg_wdata[11:0];
			if (reg_write && reg_addr == `SFRCS_OFS_CTRL && flash_cs_n)
				pol_reg <= reg_wdata[`SFRCS_CTRL_POL];
		end
	end
	// cycles since the serial clock last moved, for the half-period floor
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hold_cnt <= 0;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			if (sclk != sclk_q)
				hold_cnt <= 0;
			else if (hold_cnt < 1000)
				hold_cnt <= hold_cnt + 1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_stat_rd;
		reg_read && reg_addr == `SFRCS_OFS_STATUS;
	endsequence
	sequence s_lead;
		$stable(sclk) [*4] ##1 $changed(sclk);
	endsequence
	a_mask_readback: assert property (
		reg_read && reg_addr == `SFRCS_OFS_MASK |=> reg_rdata == {20'h0, mask_reg})
		else $error("mask read-back wrong");
	a_all_masked: assert property (
		s_stat_rd ##0 mask_reg == 12'hFFF |=> reg_rdata == 32'h0)
		else $error("masked status not zero");
	a_ready_tracks: assert property (
		s_stat_rd ##0 !mask_reg[1] |=> reg_rdata[1] == $past(flash_cs_n))
		else $error("ready bit disagrees with select");
	a_done_clear: assert property (
		s_stat_rd ##0 (!mask_reg[0] && !flash_cs_n) |=> !reg_rdata[0])
		else $error("done set during frame");
	a_wq_levels: assert property (
		s_stat_rd ##0 mask_reg[7:6] == 2'h0 |=> reg_rdata[7:6] == 2'h1)
		else $error("write queue level bits wrong");
	a_wq_flags: assert property (
		s_stat_rd |=> reg_rdata[31:10] == 22'h0)
		else $error("write queue flow bits set");
	a_wq_burst: assert property (
		s_stat_rd ##0 !mask_reg[3] |=> reg_rdata[3])
		else $error("write burst bit clear");
	a_sclk_idle: assert property (
		flash_cs_n && pol_reg == $past(pol_reg) |-> sclk == pol_reg)
		else $error("clock not at idle level");
	a_sclk_half: assert property (
		$changed(sclk) && !flash_cs_n |=> $stable(sclk) [*3])
		else $error("clock half period too short");
	a_frame_lead: assert property (
		$fell(flash_cs_n) |-> s_lead)
		else $error("first clock edge misplaced");
	a_sclk_spacing: assert property (
		$changed(sclk) && !flash_cs_n |-> hold_cnt >= SCLK_HALF_CYC - 1)
		else $error("serial clock edges too close");
endmodule // sfrcs_props
bind sfrcs_top sfrcs_props #(.SCLK_HALF_CYC(SCLK_HALF_CYC)) u_props (
	.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.sclk(sclk), .flash_cs_n(flash_cs_n), .flash_din(flash_din)
);
`default_nettype wire

// ### tb/sfrcs_flash_model.sv
// Purpose: serial flash streaming a counting byte pattern, msb first
// Assumes: bench tells which clock edge the host captures on
// Notes: data moves only on the other edge; on deselect the line flips
`default_nettype none
module sfrcs_flash_model (
	input wire logic sclk,
	input wire logic flash_cs_n,
	input wire logic samp_rise,
	output logic flash_din
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned bit_idx = 0;
	logic [7:0] cur;
	logic cs_q = 1'b1;
	// one process owns the data line: select edges restart or release it,
	// clock edges either count a capture or move on to the next bit
	always @(sclk or flash_cs_n) begin
		if (flash_cs_n !== cs_q) begin
			cs_q = flash_cs_n;
			if (flash_cs_n === 1'b0) begin
				bit_idx = 0;
				cur = 8'h3C;
				flash_din = cur[7];
			end else begin
				// stale data must not look valid once released
				flash_din = ~flash_din;
			end
		end else if (flash_cs_n === 1'b0) begin
			if (sclk === samp_rise)
				bit_idx++;
			else begin
				cur = 8'h1D * 8'(bit_idx / 8) + 8'h3C;
				flash_din = cur[7 - bit_idx % 8];
			end
		end
	end
endmodule // sfrcs_flash_model
`default_nettype wire

// ### tb/sfrcs_top_bench.sv
// Purpose: self-checking bench for the serial flash read engine
// Assumes: divider left at four clocks per half period
// Notes: mask is opened after the reset checks so status bits are visible
`include "sfrcs_consts.vh"
`default_nettype none
module sfrcs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic sclk;
	logic flash_cs_n;
	logic flash_din;
	logic samp_rise = 1'b1;
	logic [31:0] d;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int rises = 0;
	sfrcs_top #(.SCLK_HALF_CYC(4)) dut (
		.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.sclk(sclk), .flash_cs_n(flash_cs_n), .flash_din(flash_din)
	);
	sfrcs_flash_model flash (
		.sclk(sclk), .flash_cs_n(flash_cs_n), .samp_rise(samp_rise), .flash_din(flash_din)
	);
	initial begin
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			report_and_stop();
		end
	end
	always @(posedge sclk) begin
		if (flash_cs_n === 1'b0)
			rises++;
	end
	task automatic report_and_stop;
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
		@(posedge clock);
	endtask
	function automatic logic [31:0] exp_word(input int first, input int nb);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < nb; i++)
			w[8*i +: 8] = 8'h1D * 8'(first + i) + 8'h3C;
		return w;
	endfunction
	task automatic pop_check(input int first, input int nb);
		rd(`SFRCS_OFS_DATA, d);
		check(d, exp_word(first, nb));
	endtask
	task automatic stat_check(input logic [31:0] exp);
		rd(`SFRCS_OFS_STATUS, d);
		check(d, exp);
	endtask
	task automatic wait_idle;
		@(posedge clock);
		for (int i = 0; i < 20000 && flash_cs_n !== 1'b1; i++)
			@(posedge clock);
		check({31'h0, flash_cs_n}, 32'h1);
	endtask
	task automatic run_xfer(input logic pol, input logic pha, input logic capt, input logic [19:0] n);
		samp_rise = (pol == pha) ^ capt;
		wr(`SFRCS_OFS_TIMING, {25'h0, capt, 6'h0});
		wr(`SFRCS_OFS_CTRL, {23'h0, pol, pha, 7'h0});
		wr(`SFRCS_OFS_RD_COUNT, {12'h0, n});
		wr(`SFRCS_OFS_CTRL, {16'h0, 1'b1, 6'h0, pol, pha, 7'h0});
	endtask
	task automatic scn_reset;
		logic [7:0] a [6];
		logic [31:0] e [6];
		a = '{8'h20, 8'h24, 8'h28, 8'h30, 8'h2C, 8'h3C};
		e = '{32'h0, 32'h0, 32'h0, 32'h00000FFF, 32'h0, 32'h0};
		foreach (a[i]) begin
			rd(a[i], d);
			check(d, e[i]);
		end
	endtask
	task automatic scn_modes;
		for (int m = 0; m < 8; m++) begin
			run_xfer(m[2], m[1], m[0], 20'h5);
			wait_idle();
			pop_check(0, 4);
			pop_check(4, 1);
		end
		rd(`SFRCS_OFS_CTRL, d);
		check(d, 32'h00000180);
		rd(`SFRCS_OFS_TIMING, d);
		check(d, 32'h00000040);
	endtask
	task automatic scn_status;
		run_xfer(1'b0, 1'b0, 1'b0, 20'h5);
		wait_idle();
		wr(`SFRCS_OFS_SECONDARY_CONFIG, 32'h00003200);
		wr(`SFRCS_OFS_MASK, 32'h0);
		stat_check(32'h4F);
		pop_check(0, 4);
		stat_check(32'h4B);
		pop_check(4, 1);
		pop_check(0, 0);
		stat_check(32'h15B);
		wr(`SFRCS_OFS_CLEAR, 32'h100);
		stat_check(32'h5B);
		wr(`SFRCS_OFS_MASK, 32'hFFE);
		stat_check(32'h1);
		rd(`SFRCS_OFS_RAW, d);
		check(d, 32'h0000005B);
		wr(`SFRCS_OFS_MASK, 32'h0);
	endtask
	task automatic scn_stall;
		int base;
		run_xfer(1'b0, 1'b0, 1'b0, 20'h28);
		for (int i = 0; i < 300; i++) begin
			rd(`SFRCS_OFS_STATUS, d);
			if (d[5] === 1'b1)
				break;
			repeat (8) @(posedge clock);
		end
		check(d, 32'h6C);
		base = rises;
		repeat (64) @(posedge clock);
		check(32'(rises - base), 32'h0);
		check({31'h0, sclk}, 32'h0);
		for (int i = 0; i < 8; i++)
			pop_check(4 * i, 4);
		wait_idle();
		pop_check(32, 4);
		pop_check(36, 4);
	endtask
	task automatic scn_continuous;
		int base;
		int nb;
		run_xfer(1'b0, 1'b0, 1'b0, 20'h0);
		base = rises;
		repeat (300) @(posedge clock);
		wr(`SFRCS_OFS_CTRL, 32'h00004000);
		wait_idle();
		nb = (rises - base) / 8;
		check(32'((rises - base) % 8), 32'h0);
		check(32'(nb > 3), 32'h1);
		for (int w = 0; w * 4 < nb; w++)
			pop_check(4 * w, (nb - 4 * w > 4) ? 4 : nb - 4 * w);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		scn_reset();
		scn_modes();
		scn_status();
		scn_stall();
		scn_continuous();
		report_and_stop();
	end
endmodule // sfrcs_top_bench
`default_nettype wire
